// File: hdl/uaco_pkg.sv
package uaco_pkg;
  // ---------------------------------------------------------------
  // queue geometry
  // ---------------------------------------------------------------
  localparam int        QAW       = 5;
  localparam logic [5:0] CAP_FULL = 6'h20;
  localparam logic [5:0] CAP_ONE  = 6'h01;
  localparam int        RXW       = 11;
  // ---------------------------------------------------------------
  // oversampling modes and bit lengths in sampling clocks
  // ---------------------------------------------------------------
  localparam logic [1:0] OSR_8X   = 2'h1;
  localparam logic [1:0] OSR_4X   = 2'h2;
  localparam logic [4:0] BIT_16X  = 5'h10;
  localparam logic [4:0] BIT_8X   = 5'h08;
  localparam logic [4:0] BIT_4X   = 5'h04;
  // ---------------------------------------------------------------
  // divisor and prescaler
  // ---------------------------------------------------------------
  localparam logic [19:0] DIV_ONE = 20'h00010;
  localparam logic [20:0] ACC_STEP = 21'h000010;
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam int        MC_PRE    = 7;
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int        LC_STOP   = 2;
  localparam int        LC_PEN    = 3;
  localparam int        LC_EVEN   = 4;
  localparam int        FC_EN     = 0;
  localparam int        IE_RX     = 0;
  localparam int        IE_TX     = 1;
  localparam logic [3:0] WL_BASE  = 4'h5;
  // ---------------------------------------------------------------
  // receive trigger levels and timeout
  // ---------------------------------------------------------------
  localparam logic [5:0] TRIG_0   = 6'h08;
  localparam logic [5:0] TRIG_1   = 6'h10;
  localparam logic [5:0] TRIG_2   = 6'h18;
  localparam logic [5:0] TRIG_3   = 6'h1E;
  localparam logic [5:0] TO_WORDS = 6'h04;
  localparam logic [5:0] TO_EXTRA = 6'h0C;
  // ---------------------------------------------------------------
  // interrupt status codes
  // ---------------------------------------------------------------
  localparam logic [3:0] IS_NONE  = 4'h1;
  localparam logic [3:0] IS_TXE   = 4'h2;
  localparam logic [3:0] IS_RXRDY = 4'h4;
  localparam logic [3:0] IS_RXTO  = 4'hC;
  // ---------------------------------------------------------------
  // serial state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h2,
    ST_PAR   = 3'h3,
    ST_STOP  = 3'h4
  } uaco_st_t;
endpackage

// File: hdl/uaco_mem.sv
`timescale 1ns/1ps
module uaco_mem #(
  parameter int W  = 8,
  parameter int AW = 5
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_r
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [W-1:0] mem [(1<<AW)];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem[raddr];
    end
  end
endmodule

// File: hdl/uaco_core.sv
// Function
// R1: transmit shifter is 8 bits, fed from a 32-byte queue
// R2: each serial bit lasts 16, 8 or 4 sampling clocks
// R3: frame is start, data bits, optional parity, then stop bits
// R4: data leaves least significant bit first
// R5: each host byte write stores one byte and bumps the write pointer unless the queue is full
// R6: non-queued mode sets holding-empty when byte moves to shifter
// R7: holding-empty raises transmit-empty interrupt only with enable bit 1
// R8: non-queued mode sets transmitter-empty only when shifter is empty
// R9: queued mode holding-empty follows empty queue and raises interrupt
// R10: queued mode transmitter-empty needs empty queue and empty shifter
// R11: receive shifter is 8 bits timed by selected sampling clock
// R12: start edge validated after 8, 4 or 2 clocks if still low
// R13: data and stop bits sampled at their centre the same way
// R14: receive errors show in line-status bits 2 to 4
// R15: reading a byte bumps read pointer and refreshes error flags
// R16: data-ready interrupt per character or at trigger level
// R17: timeout after 4 word lengths plus 12 bit times idle
// R18: data-ready interrupts only with interrupt-enable bit 0
// R19: fraction bits 5:4 pick 16x, 8x or 4x
// R20: divisor is high and low bytes plus fraction in sixteenths
// R21: modem-control bit 7 prescales the clock by 1 or 4
// R22: receive queue entries hold data plus three error tags
// R23: a false start returns the receiver to idle
`timescale 1ns/1ps
module uaco_core (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // configuration
  input  wire logic [7:0] divisor_low_byte,
  input  wire logic [7:0] divisor_high_byte,
  input  wire logic [5:0] divisor_fraction,
  input  wire logic [7:0] modem_control,
  input  wire logic [5:0] line_control,
  input  wire logic [7:0] fifo_control,
  input  wire logic [1:0] interrupt_enable,
  // host side
  input  wire logic       tx_wr,
  input  wire logic [7:0] transmit_byte_input,
  input  wire logic       rx_rd,
  input  wire logic       lsr_rd,
  input  wire logic       isr_rd,
  output logic      [7:0] receive_byte_output,
  output logic      [7:0] line_status,
  output logic      [3:0] interrupt_status,
  output logic            irq,
  // serial line
  input  wire logic       ser_in,
  output logic            ser_out
);
  // ---------------------------------------------------------------
  // baud generator and frame format
  // ---------------------------------------------------------------
  logic [1:0]  pre_cnt_r;
  logic [20:0] acc_r;
  wire         pre_on   = modem_control[uaco_pkg::MC_PRE];
  wire         pre_tick = !pre_on || (pre_cnt_r == uaco_pkg::PRE_LAST); // R21
  wire [19:0]  div16    = {divisor_high_byte, divisor_low_byte,
                           divisor_fraction[3:0]}; // R20
  wire [19:0]  div_eff  = (div16 < uaco_pkg::DIV_ONE) ?
                          uaco_pkg::DIV_ONE : div16;
  wire [20:0]  acc_sum  = acc_r + uaco_pkg::ACC_STEP;
  wire         samp     = pre_tick && (acc_sum >= {1'b0, div_eff});
  wire [20:0]  acc_nxt  = !pre_tick ? acc_r :
                          samp ? acc_sum - {1'b0, div_eff} : acc_sum;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_r <= 2'h0;
      acc_r     <= 21'h000000;
    end else begin
      pre_cnt_r <= pre_cnt_r + 2'h1;
      acc_r     <= acc_nxt;
    end
  end
  wire [1:0] osr_sel = divisor_fraction[5:4];
  wire [4:0] osr     = (osr_sel == uaco_pkg::OSR_8X) ? uaco_pkg::BIT_8X :
                       (osr_sel == uaco_pkg::OSR_4X) ? uaco_pkg::BIT_4X :
                       uaco_pkg::BIT_16X; // R19
  wire [4:0] osr_end  = osr - 5'h01;
  wire [4:0] half_end = (osr >> 1) - 5'h01;
  wire [3:0] nbits    = uaco_pkg::WL_BASE + {2'h0, line_control[1:0]};
  wire [2:0] last_bit = 3'(nbits - 4'h1);
  wire [7:0] dmask    = 8'hFF >> (4'h8 - nbits);
  wire       pen      = line_control[uaco_pkg::LC_PEN];
  wire       even     = line_control[uaco_pkg::LC_EVEN];
  wire       two_stop = line_control[uaco_pkg::LC_STOP];
  wire       fifo_en  = fifo_control[uaco_pkg::FC_EN];
  wire [5:0] cap      = fifo_en ? uaco_pkg::CAP_FULL : uaco_pkg::CAP_ONE;
  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic [4:0] tx_wp_r;
  logic [4:0] tx_rp_r;
  logic [5:0] tx_cnt_r;
  logic       tx_avail_r;
  logic [7:0] tx_head;
  uaco_pkg::uaco_st_t tx_st_r;
  wire tx_push = tx_wr && (tx_cnt_r < cap); // R5
  wire tx_pop  = (tx_st_r == uaco_pkg::ST_IDLE) && (tx_cnt_r != 6'h00) &&
                 tx_avail_r;
  uaco_mem #(.W(8), .AW(uaco_pkg::QAW)) u_tx_mem (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .we      (tx_push),
    .waddr   (tx_wp_r),
    .wdata   (transmit_byte_input),
    .raddr   (tx_rp_r),
    .rdata_r (tx_head)
  ); // R1
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_r    <= 5'h00;
      tx_rp_r    <= 5'h00;
      tx_cnt_r   <= 6'h00;
      tx_avail_r <= 1'b0;
    end else begin
      tx_wp_r    <= tx_wp_r + {4'h0, tx_push}; // R5
      tx_rp_r    <= tx_rp_r + {4'h0, tx_pop};
      tx_cnt_r   <= tx_cnt_r + {5'h00, tx_push} - {5'h00, tx_pop};
      tx_avail_r <= (tx_cnt_r != 6'h00) && !tx_pop;
    end
  end
  logic [4:0] tx_tick_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic       tx_par_r;
  logic       ser_out_r;
  wire        tx_bend = samp && (tx_tick_r == osr_end); // R2
  wire [7:0]  tx_md   = tx_head & dmask;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r   <= uaco_pkg::ST_IDLE;
      tx_tick_r <= 5'h00;
      tx_bit_r  <= 3'h0;
      tx_sh_r   <= 8'h00;
      tx_par_r  <= 1'b0;
      ser_out_r <= 1'b1;
    end else begin
      if (tx_st_r != uaco_pkg::ST_IDLE && samp) begin
        tx_tick_r <= tx_bend ? 5'h00 : tx_tick_r + 5'h01;
      end
      case (tx_st_r)
        uaco_pkg::ST_IDLE: begin
          ser_out_r <= 1'b1;
          tx_tick_r <= 5'h00;
          if (tx_pop) begin
            tx_sh_r   <= tx_head; // R1
            tx_par_r  <= (^tx_md) ^ !even;
            ser_out_r <= 1'b0; // R3
            tx_st_r   <= uaco_pkg::ST_START;
          end
        end
        uaco_pkg::ST_START: begin
          if (tx_bend) begin
            ser_out_r <= tx_sh_r[0]; // R4
            tx_bit_r  <= 3'h0;
            tx_st_r   <= uaco_pkg::ST_DATA;
          end
        end
        uaco_pkg::ST_DATA: begin
          if (tx_bend) begin
            if (tx_bit_r == last_bit) begin
              ser_out_r <= pen ? tx_par_r : 1'b1; // R3
              tx_bit_r  <= 3'h0;
              tx_st_r   <= pen ? uaco_pkg::ST_PAR : uaco_pkg::ST_STOP;
            end else begin
              ser_out_r <= tx_sh_r[1]; // R4
              tx_sh_r   <= tx_sh_r >> 1;
              tx_bit_r  <= tx_bit_r + 3'h1;
            end
          end
        end
        uaco_pkg::ST_PAR: begin
          if (tx_bend) begin
            ser_out_r <= 1'b1;
            tx_st_r   <= uaco_pkg::ST_STOP;
          end
        end
        uaco_pkg::ST_STOP: begin
          if (tx_bend) begin
            if (two_stop && tx_bit_r == 3'h0) begin
              tx_bit_r <= 3'h1;
            end else begin
              tx_st_r <= uaco_pkg::ST_IDLE;
            end
          end
        end
        default: tx_st_r <= uaco_pkg::ST_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  logic       rx_prev_r;
  logic [4:0] rx_tick_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic       rx_pe_r;
  logic       rx_pbit_r;
  logic       rx_done_r;
  logic [2:0] rx_tag_r;
  uaco_pkg::uaco_st_t rx_st_r;
  wire        rx_fall = rx_prev_r && !ser_in;
  wire        rx_mid  = samp && (rx_tick_r == half_end); // R12
  wire        rx_bend = samp && (rx_tick_r == osr_end); // R13
  wire        rx_exp  = (^(rx_sh_r & dmask)) ^ !even;
  wire        rx_brk  = !ser_in && (rx_sh_r == 8'h00) &&
                        (!pen || !rx_pbit_r);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_r <= 1'b1;
      rx_st_r   <= uaco_pkg::ST_IDLE;
      rx_tick_r <= 5'h00;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_pe_r   <= 1'b0;
      rx_pbit_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_tag_r  <= 3'h0;
    end else begin
      rx_prev_r <= ser_in;
      rx_done_r <= 1'b0;
      if (rx_st_r != uaco_pkg::ST_IDLE && samp) begin
        rx_tick_r <= rx_bend ? 5'h00 : rx_tick_r + 5'h01;
      end
      case (rx_st_r)
        uaco_pkg::ST_IDLE: begin
          rx_tick_r <= 5'h00;
          if (rx_fall) begin
            rx_sh_r <= 8'h00;
            rx_pe_r <= 1'b0;
            rx_st_r <= uaco_pkg::ST_START;
          end
        end
        uaco_pkg::ST_START: begin
          if (rx_mid) begin
            rx_tick_r <= 5'h00;
            rx_bit_r  <= 3'h0;
            if (!ser_in) begin
              rx_st_r <= uaco_pkg::ST_DATA; // R12
            end else begin
              rx_st_r <= uaco_pkg::ST_IDLE; // R23
            end
          end
        end
        uaco_pkg::ST_DATA: begin
          if (rx_bend) begin
            rx_sh_r[rx_bit_r] <= ser_in; // R11
            rx_bit_r          <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit) begin
              rx_st_r <= pen ? uaco_pkg::ST_PAR : uaco_pkg::ST_STOP;
            end
          end
        end
        uaco_pkg::ST_PAR: begin
          if (rx_bend) begin
            rx_pbit_r <= ser_in;
            rx_pe_r   <= ser_in != rx_exp; // R14
            rx_st_r   <= uaco_pkg::ST_STOP;
          end
        end
        uaco_pkg::ST_STOP: begin
          if (rx_bend) begin
            rx_tag_r  <= {rx_brk, !ser_in, rx_pe_r}; // R14
            rx_done_r <= 1'b1; // R13
            rx_st_r   <= uaco_pkg::ST_IDLE;
          end
        end
        default: rx_st_r <= uaco_pkg::ST_IDLE;
      endcase
    end
  end
  logic [4:0]  rx_wp_r;
  logic [4:0]  rx_rp_r;
  logic [5:0]  rx_cnt_r;
  logic [10:0] rx_head;
  wire         rx_push = rx_done_r && (rx_cnt_r < cap);
  wire         rx_ovf  = rx_done_r && (rx_cnt_r == cap);
  wire         rx_pop  = rx_rd && (rx_cnt_r != 6'h00); // R15
  wire         rx_any  = rx_cnt_r != 6'h00;
  uaco_mem #(.W(uaco_pkg::RXW), .AW(uaco_pkg::QAW)) u_rx_mem (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .we      (rx_push),
    .waddr   (rx_wp_r),
    .wdata   ({rx_tag_r, rx_sh_r}),
    .raddr   (rx_rp_r),
    .rdata_r (rx_head)
  ); // R22
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_r  <= 5'h00;
      rx_rp_r  <= 5'h00;
      rx_cnt_r <= 6'h00;
    end else begin
      rx_wp_r  <= rx_wp_r + {4'h0, rx_push};
      rx_rp_r  <= rx_rp_r + {4'h0, rx_pop}; // R15
      rx_cnt_r <= rx_cnt_r + {5'h00, rx_push} - {5'h00, rx_pop};
    end
  end
  logic [10:0] to_cnt_r;
  logic        rx_to_r;
  wire  [5:0]  to_bits = 6'(uaco_pkg::TO_WORDS * {2'h0, nbits} +
                            uaco_pkg::TO_EXTRA); // R17
  wire  [10:0] to_lim  = {5'h00, to_bits} * {6'h00, osr};
  wire         to_rst  = rx_push || rx_pop || !rx_any || !fifo_en;
  wire         to_hit  = to_cnt_r == to_lim;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      to_cnt_r <= 11'h000;
      rx_to_r  <= 1'b0;
    end else if (to_rst) begin
      to_cnt_r <= 11'h000;
      rx_to_r  <= 1'b0;
    end else begin
      to_cnt_r <= (samp && !to_hit) ? to_cnt_r + 11'h001 : to_cnt_r;
      rx_to_r  <= rx_to_r || to_hit; // R17
    end
  end
  // ---------------------------------------------------------------
  // status and interrupts
  // ---------------------------------------------------------------
  logic       ovr_r;
  logic       txe_r;
  logic [7:0] lsr_r;
  logic [3:0] isr_r;
  logic       irq_r;
  wire  [1:0] trig_sel = fifo_control[7:6];
  wire  [5:0] trig     = (trig_sel == 2'h0) ? uaco_pkg::TRIG_0 :
                         (trig_sel == 2'h1) ? uaco_pkg::TRIG_1 :
                         (trig_sel == 2'h2) ? uaco_pkg::TRIG_2 :
                         uaco_pkg::TRIG_3;
  wire        rx_lvl   = fifo_en ? (rx_cnt_r >= trig) : rx_any; // R16
  wire        ie_rx    = interrupt_enable[uaco_pkg::IE_RX];
  wire        ie_tx    = interrupt_enable[uaco_pkg::IE_TX];
  wire        thre     = tx_cnt_r == 6'h00; // R6 R9
  wire        temt     = thre && (tx_st_r == uaco_pkg::ST_IDLE); // R8 R10
  wire        txe_set  = tx_pop && (tx_cnt_r == 6'h01); // R6 R9
  wire        txe_clr  = tx_wr || (isr_rd && isr_r == uaco_pkg::IS_TXE);
  wire  [2:0] rx_errs  = rx_any ? rx_head[10:8] : 3'h0; // R14 R15
  wire  [3:0] is_cur   = (ie_rx && rx_to_r) ? uaco_pkg::IS_RXTO :
                         (ie_rx && rx_lvl) ? uaco_pkg::IS_RXRDY : // R18
                         (ie_tx && txe_r) ? uaco_pkg::IS_TXE : // R7
                         uaco_pkg::IS_NONE;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_r <= 1'b0;
      txe_r <= 1'b0;
      lsr_r <= 8'h60;
      isr_r <= uaco_pkg::IS_NONE;
      irq_r <= 1'b0;
    end else begin
      ovr_r <= rx_ovf || (ovr_r && !lsr_rd);
      txe_r <= txe_set || (txe_r && !txe_clr); // R7 R9
      lsr_r <= {1'b0, temt, thre, rx_errs, ovr_r, rx_any};
      isr_r <= is_cur;
      irq_r <= is_cur != uaco_pkg::IS_NONE;
    end
  end
  assign receive_byte_output = rx_head[7:0];
  assign line_status         = lsr_r;
  assign interrupt_status    = isr_r;
  assign irq                 = irq_r;
  assign ser_out             = ser_out_r;
endmodule

// File: testbench/uaco_core_properties.sv
`timescale 1ns/1ps
module uaco_core_chk (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // configuration
  input wire logic [7:0] divisor_low_byte,
  input wire logic [7:0] divisor_high_byte,
  input wire logic [5:0] divisor_fraction,
  input wire logic [7:0] modem_control,
  input wire logic [7:0] fifo_control,
  input wire logic [1:0] interrupt_enable,
  // host side
  input wire logic       tx_wr,
  input wire logic       rx_rd,
  input wire logic [7:0] line_status,
  input wire logic [3:0] interrupt_status,
  input wire logic       irq,
  // serial line
  input wire logic       ser_out
);
  logic fast;
  assign fast = divisor_low_byte == 8'h01 && divisor_high_byte == 8'h00 &&
                divisor_fraction == 6'h20 && !modem_control[7];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_IRQ: assert property (
    irq == (interrupt_status != uaco_pkg::IS_NONE))
    else $error("irq disagrees with status");
  AST_TEMT: assert property (line_status[6] |-> line_status[5])
    else $error("shifter empty flag without queue empty");
  AST_IDLE: assert property (
    line_status[6] && $past(line_status[6]) |-> ser_out)
    else $error("line not idle while transmitter empty");
  AST_START: assert property (fast && $fell(ser_out) |-> !ser_out[*3])
    else $error("start bit too short");
  AST_RXIE: assert property (
    !interrupt_enable[0] && !$past(interrupt_enable[0]) |->
    interrupt_status != uaco_pkg::IS_RXRDY &&
    interrupt_status != uaco_pkg::IS_RXTO)
    else $error("receive interrupt while disabled");
  AST_TXIE: assert property (
    !interrupt_enable[1] && !$past(interrupt_enable[1]) |->
    interrupt_status != uaco_pkg::IS_TXE)
    else $error("transmit interrupt while disabled");
  AST_TOQ: assert property (
    !fifo_control[0] && !$past(fifo_control[0]) |->
    interrupt_status != uaco_pkg::IS_RXTO)
    else $error("timeout outside queued mode");
  AST_DRF: assert property (
    $fell(line_status[0]) |->
    $past(rx_rd) || $past(rx_rd, 2) || $past(rx_rd, 3))
    else $error("data ready dropped without a read");
  AST_TEMTF: assert property (
    $fell(line_status[6]) |->
    $past(tx_wr) || $past(tx_wr, 2) || $past(tx_wr, 3))
    else $error("transmitter busy without a write");
endmodule
bind uaco_core uaco_core_chk u_chk (
  .mclk, .rst_n, .divisor_low_byte, .divisor_high_byte,
  .divisor_fraction, .modem_control, .fifo_control, .interrupt_enable,
  .tx_wr, .rx_rd, .line_status, .interrupt_status, .irq, .ser_out
);

// File: testbench/uaco_remote.sv
`timescale 1ns/1ps
module uaco_remote (
  // clock
  input  wire logic mclk,
  // serial lines
  input  wire logic line_in,
  output logic      line_out
);
  int         bitc = 4;
  int         ferr = 0;
  logic [7:0] got [$];
  logic [9:0] sh;
  initial line_out = 1'b1;
  // one frame: start, data lsb first, even parity, stop
  task automatic send(input logic [7:0] d, input logic bp, input logic bs);
    logic [10:0] f;
    f = {~bs, (^d) ^ bp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge mclk);
      line_out <= f[i];
      repeat (bitc - 1) @(negedge mclk);
    end
    @(negedge mclk);
    line_out <= 1'b1;
  endtask
  // low pulse far shorter than half a bit
  task automatic glitch();
    @(negedge mclk);
    line_out <= 1'b0;
    @(negedge mclk);
    line_out <= 1'b1;
  endtask
  // frame decoder sampling at bit centres
  always begin
    @(negedge line_in);
    repeat (bitc / 2) @(negedge mclk);
    for (int i = 0; i < 10; i++) begin
      repeat (bitc) @(negedge mclk);
      sh[i] = line_in;
    end
    got.push_back(sh[7:0]);
    if (sh[8] !== ^sh[7:0] || sh[9] !== 1'b1) ferr++;
  end
endmodule

// File: testbench/test_uaco_core.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  mismatches++; $display("CHECK FAILED %0t got %0h exp %0h", \
  $time, a, b); end end
`define WAITF(c, n) begin wc = 0; \
  while (!(c) && wc < (n)) begin @(negedge mclk); wc++; end \
  if (!(c)) begin mismatches++; \
  $display("CHECK FAILED %0t wait ran out", $time); stop_test(); end end
module test_uaco_core;
  logic       mclk = 1'b0;
  logic       rst_n, tx_wr, rx_rd, lsr_rd, isr_rd, irq, ser_in, ser_out;
  logic [7:0] dl, dh, mc, fc, tb_byte, rv, rbo, ls, g;
  logic [5:0] df, lc;
  logic [3:0] ist;
  logic [1:0] ie;
  int         mismatches, checks_done, wc, e;
  int         exp_tx [$];
  int         exp_rx [$];
  int         m_df [5] = '{6'h00, 6'h10, 6'h20, 6'h20, 6'h28};
  int         m_mc [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  int         m_bc [5] = '{16, 8, 4, 16, 6};
  always #20 mclk = ~mclk;
  uaco_core uut (
    .mclk(mclk), .rst_n(rst_n), .divisor_low_byte(dl),
    .divisor_high_byte(dh), .divisor_fraction(df), .modem_control(mc),
    .line_control(lc), .fifo_control(fc), .interrupt_enable(ie),
    .tx_wr(tx_wr), .transmit_byte_input(tb_byte), .rx_rd(rx_rd),
    .lsr_rd(lsr_rd), .isr_rd(isr_rd), .receive_byte_output(rbo),
    .line_status(ls), .interrupt_status(ist), .irq(irq),
    .ser_in(ser_in), .ser_out(ser_out)
  );
  uaco_remote rem (.mclk(mclk), .line_in(ser_out), .line_out(ser_in));
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wr_n(input int n);
    @(negedge mclk);
    tx_wr <= 1'b1;
    repeat (n) begin
      rv = lfsr(rv);
      tb_byte <= rv;
      exp_tx.push_back(rv);
      @(negedge mclk);
    end
    tx_wr <= 1'b0;
  endtask
  task automatic chk_tx(input int n);
    `WAITF(rem.got.size() == n, n * 250 + 100)
    repeat (n) begin
      g = rem.got.pop_front();
      e = exp_tx.pop_front();
      `CHK(g, e[7:0])
    end
    `CHK(rem.ferr, 0)
  endtask
  task automatic rx_one(input logic [7:0] d, input logic bp, input logic bs);
    exp_rx.push_back({1'b0, bs, bp, d});
    rem.send(d, bp, bs);
  endtask
  task automatic rd();
    `WAITF(ls[0] === 1'b1, 100)
    @(negedge mclk);
    e = exp_rx.pop_front();
    `CHK(rbo, e[7:0])
    `CHK(ls[4:2], e[10:8])
    @(negedge mclk);
    rx_rd <= 1'b1;
    @(negedge mclk);
    rx_rd <= 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0; dl = 8'h01; dh = 8'h00; df = 6'h20; mc = 8'h00;
    lc = 6'h1B; fc = 8'h01; ie = 2'h0; tx_wr = 1'b0; tb_byte = 8'h00;
    rx_rd = 1'b0; lsr_rd = 1'b0; isr_rd = 1'b0; rv = 8'h60;
    mismatches = 0;
    checks_done = 0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    `CHK(ls, 8'h60)
    `CHK(ist, 4'h1)
    `CHK(irq, 1'b0)
    `CHK(ser_out, 1'b1)
    `CHK(rbo, 8'h00)
    done("reset");
    for (int i = 0; i < 5; i++) begin
      @(negedge mclk);
      df <= m_df[i][5:0];
      mc <= m_mc[i][7:0];
      rem.bitc = m_bc[i];
      repeat (4) @(negedge mclk);
      wr_n(1);
      chk_tx(1);
      rv = lfsr(rv);
      rx_one(rv, 1'b0, 1'b0);
      rd();
    end
    df <= 6'h20;
    mc <= 8'h00;
    rem.bitc = 4;
    ie <= 2'h2;
    done("modes");
    wr_n(32);
    `CHK(ls[5], 1'b0)
    chk_tx(32);
    `WAITF(ls[6] === 1'b1, 100)
    `CHK(ist, uaco_pkg::IS_TXE)
    `CHK(irq, 1'b1)
    isr_rd <= 1'b1;
    @(negedge mclk);
    isr_rd <= 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(ist, uaco_pkg::IS_NONE)
    fc <= 8'h00;
    ie <= 2'h1;
    done("burst");
    wr_n(1);
    repeat (8) @(negedge mclk);
    `CHK(ls[5], 1'b1)
    `CHK(ls[6], 1'b0)
    chk_tx(1);
    rv = lfsr(rv);
    rx_one(rv, 1'b0, 1'b0);
    `WAITF(ist === uaco_pkg::IS_RXRDY, 20)
    `CHK(irq, 1'b1)
    rd();
    `CHK(ist, uaco_pkg::IS_NONE)
    fc <= 8'h01;
    done("single");
    rem.glitch();
    repeat (60) @(negedge mclk);
    `CHK(ls[0], 1'b0)
    rx_one(8'hA5, 1'b1, 1'b0);
    rx_one(8'h5A, 1'b0, 1'b1);
    repeat (150) @(negedge mclk);
    `CHK(ist, uaco_pkg::IS_NONE)
    `WAITF(ist === uaco_pkg::IS_RXTO, 60)
    `CHK(irq, 1'b1)
    rd();
    rd();
    `CHK(ist, uaco_pkg::IS_NONE)
    done("errors");
    repeat (7) begin
      rv = lfsr(rv);
      rx_one(rv, 1'b0, 1'b0);
    end
    `CHK(ist, uaco_pkg::IS_NONE)
    rv = lfsr(rv);
    rx_one(rv, 1'b0, 1'b0);
    repeat (4) @(negedge mclk);
    `CHK(ist, uaco_pkg::IS_RXRDY)
    ie <= 2'h0;
    repeat (3) @(negedge mclk);
    `CHK(ist, uaco_pkg::IS_NONE)
    repeat (8) rd();
    done("trigger");
    stop_test();
  end
endmodule
